/* File: fsp_ctrl.sv */
`default_nettype none
// How it works
// - software protect flag clears at every reset.
// - unconnected write-protect pin reads as deasserted.
// - pin low blocks map change and protected-sector program or erase.
// - pin only adds protection, never removes software protection.
// - pin low turns protection on within the assert delay.
// - pin high drops protection within release delay unless software enabled.
// - software-enabled protection survives pin release until disable command.
// - disable command while pin low is ignored.
// - pin is filtered against short glitches.
// - sixteen-byte map, byte n guards sector n.
// - sectors 1-15: ffh protected, 00h unprotected.
// - byte 0 bits 7:6 guard pages 0-7, bits 5:4 pages 8-255.
// - map holds 00h out of reset.
// - map must be erased before program is accepted.
// - map erase sequence starts on chip-select rise.
// - busy shown during self-timed map erase.
// - erase accepted with software protection on or off, refused with pin low, leaves all ffh.
// - after erase with protection on, every sector operation refused.
// - enable sequence takes effect on chip-select rise.
// - disable sequence takes effect on chip-select rise.
// - status shows protection enabled by either method.
module fsp_ctrl #(
  parameter int unsigned ERASE_CYC   = fsp_pkg::PROTECT_MAP_ERASE_CYC,
  parameter int unsigned PROGRAM_CYC = fsp_pkg::MAP_PROGRAM_CYC
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // serial command pins
  input  wire logic                      csN,
  input  wire logic                      sck,
  input  wire logic                      si,
  // write-protect pin
  input  wire logic                      wpN,
  // array operation check
  input  wire logic                      opReq,
  input  wire logic [fsp_pkg::ADDR_W-1:0] opAddr,
  output var  logic                      opGrant,
  output var  logic                      opDeny,
  // status
  output var  logic                      statusBusy,
  output var  logic                      statusProtect
);
  localparam int unsigned BYTE_CNT_W = 5;

  fsp_pkg::fsp_state_e            state;
  logic [2:0]                     csSync;
  logic [2:0]                     sckSync;
  logic [1:0]                     siSync;
  logic                           wpLow;
  logic                           swProtect;
  logic                           mapErased;
  logic [7:0]                     protMap [fsp_pkg::MAP_BYTES];
  logic [7:0]                     shiftReg;
  logic [2:0]                     bitCnt;
  logic [BYTE_CNT_W-1:0]          byteCnt;
  logic [31:0]                    opcode;
  logic [fsp_pkg::MAP_IDX_W-1:0]  mapIdx;
  logic [fsp_pkg::BUSY_CNT_W-1:0] busyCnt;
  logic                           csRise;
  logic                           csFall;
  logic                           sckRise;
  logic                           byteDone;
  logic [7:0]                     next_byte;
  logic                           protActive;
  logic                           mapWritable;

  initial begin
    if (ERASE_CYC < 1 || ERASE_CYC >= (1 << fsp_pkg::BUSY_CNT_W)) $error("erase count out of range");
    if (PROGRAM_CYC < 1 || PROGRAM_CYC >= (1 << fsp_pkg::BUSY_CNT_W)) $error("program count out of range");
    if (fsp_pkg::MAP_BYTES != (1 << fsp_pkg::MAP_IDX_W)) $error("map depth must match index width");
    if (fsp_pkg::SECTOR_MSB - fsp_pkg::SECTOR_LSB + 1 != fsp_pkg::MAP_IDX_W) $error("sector field must match index");
  end

  // does the map guard this address
  function automatic logic sectorGuarded(input logic [fsp_pkg::ADDR_W-1:0] addr,
                                         input logic [7:0] byte0,
                                         input logic [7:0] byteN);
    logic [7:0] page;
    page = addr[fsp_pkg::PAGE_MSB:fsp_pkg::PAGE_LSB];
    if (addr[fsp_pkg::SECTOR_MSB:fsp_pkg::SECTOR_LSB] != 4'h0) begin
      sectorGuarded = (byteN == fsp_pkg::MAP_PROTECTED);
    end else if (page <= fsp_pkg::SECTOR0_LOW_LAST_PAGE) begin
      sectorGuarded = (byte0[fsp_pkg::SECTOR0_LOW_HALF_MSB:fsp_pkg::SECTOR0_LOW_HALF_LSB]
                       == fsp_pkg::HALF_PROTECTED);
    end else begin
      sectorGuarded = (byte0[fsp_pkg::SECTOR0_HIGH_HALF_MSB:fsp_pkg::SECTOR0_HIGH_HALF_LSB]
                       == fsp_pkg::HALF_PROTECTED);
    end
  endfunction : sectorGuarded

  // match a four-byte prefixed command
  function automatic logic isCmd(input logic [31:0] seq, input logic [7:0] last);
    isCmd = (seq == {fsp_pkg::CMD_PREFIX1, fsp_pkg::CMD_PREFIX2, fsp_pkg::CMD_PREFIX3, last});
  endfunction : isCmd

  // filtered write-protect level
  fsp_wp_filter #(
    .FILTER_CYC (fsp_pkg::WP_FILTER_CYC)
  ) u_wp_filter (
    .clock  (clock),
    .nrst   (nrst),
    .wpPinN (wpN),
    .wpLow  (wpLow)
  );

  // pin synchronisers; edges read only the second and third stages
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csSync  <= 3'h7;
      sckSync <= 3'h0;
      siSync  <= 2'h0;
    end else begin
      csSync  <= {csSync[1:0], csN};
      sckSync <= {sckSync[1:0], sck};
      siSync  <= {siSync[0], si};
    end
  end

  // edge and byte events
  assign csRise      = csSync[1] & ~csSync[2];
  assign csFall      = ~csSync[1] & csSync[2];
  assign sckRise     = sckSync[1] & ~sckSync[2] & ~csSync[2];
  assign next_byte   = {shiftReg[6:0], siSync[1]};
  assign byteDone    = sckRise && (bitCnt == 3'h7);
  assign protActive  = swProtect | wpLow;
  assign mapWritable = ~wpLow & ~statusBusy;

  // bit and byte counting within one chip-select frame
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shiftReg <= 8'h00;
      bitCnt   <= 3'h0;
      byteCnt  <= '0;
      opcode   <= 32'h0;
    end else if (csFall) begin
      bitCnt  <= 3'h0;
      byteCnt <= '0;
      opcode  <= 32'h0;
    end else if (sckRise) begin
      shiftReg <= next_byte;
      bitCnt   <= bitCnt + 3'h1;
      if (byteDone && byteCnt < BYTE_CNT_W'(fsp_pkg::CMD_BYTES)) begin
        opcode  <= {opcode[23:0], next_byte};
        byteCnt <= byteCnt + 1'b1;
      end
    end
  end

  // frame state: opcode, map data or ignored
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= fsp_pkg::FSP_IDLE;
    end else begin
      case (state)
        fsp_pkg::FSP_IDLE: begin
          if (csFall) state <= fsp_pkg::FSP_OPCODE;
        end
        fsp_pkg::FSP_OPCODE: begin
          if (csRise) begin
            state <= fsp_pkg::FSP_IDLE;
          end else if (byteDone && byteCnt == BYTE_CNT_W'(fsp_pkg::CMD_BYTES - 1)) begin
            if (isCmd({opcode[23:0], next_byte}, fsp_pkg::CMD_PROGRAM_MAP) && mapWritable && mapErased)
              state <= fsp_pkg::FSP_MAPDATA;
            else
              state <= fsp_pkg::FSP_IGNORE;
          end
        end
        fsp_pkg::FSP_MAPDATA: begin
          if (csRise) state <= fsp_pkg::FSP_IDLE;
        end
        fsp_pkg::FSP_IGNORE: begin
          if (csRise) state <= fsp_pkg::FSP_IDLE;
        end
        default: begin
          state <= fsp_pkg::FSP_IDLE;
        end
      endcase
    end
  end

  // software protection flag, acted on at chip-select rise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      swProtect <= 1'b0;
    end else if (csRise && state == fsp_pkg::FSP_IGNORE && bitCnt == 3'h0
                 && byteCnt == BYTE_CNT_W'(fsp_pkg::CMD_BYTES)) begin
      if (isCmd(opcode, fsp_pkg::CMD_ENABLE_PROTECT))
        swProtect <= 1'b1;
      else if (isCmd(opcode, fsp_pkg::CMD_DISABLE_PROTECT) && !wpLow)
        swProtect <= 1'b0;
    end
  end

  // protection map: reset value, erase, and byte program with wrap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < fsp_pkg::MAP_BYTES; i++) begin
        protMap[i] <= fsp_pkg::MAP_RESET_VALUE;
      end
      mapIdx    <= '0;
      mapErased <= 1'b0;
    end else if (csRise && state == fsp_pkg::FSP_IGNORE && bitCnt == 3'h0
                 && byteCnt == BYTE_CNT_W'(fsp_pkg::CMD_BYTES)
                 && isCmd(opcode, fsp_pkg::CMD_ERASE_MAP) && mapWritable) begin
      for (int i = 0; i < fsp_pkg::MAP_BYTES; i++) begin
        protMap[i] <= fsp_pkg::MAP_ERASED_VALUE;
      end
      mapErased <= 1'b1;
    end else if (state == fsp_pkg::FSP_MAPDATA && byteDone) begin
      protMap[mapIdx] <= next_byte;
      mapIdx          <= mapIdx + 1'b1;
    end else if (state == fsp_pkg::FSP_MAPDATA && csRise) begin
      mapIdx    <= '0;
      mapErased <= 1'b0;
    end
  end

  // self-timed busy for map erase and program
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busyCnt    <= '0;
      statusBusy <= 1'b0;
    end else if (csRise && state == fsp_pkg::FSP_IGNORE && bitCnt == 3'h0
                 && byteCnt == BYTE_CNT_W'(fsp_pkg::CMD_BYTES)
                 && isCmd(opcode, fsp_pkg::CMD_ERASE_MAP) && mapWritable) begin
      busyCnt    <= fsp_pkg::BUSY_CNT_W'(ERASE_CYC - 1);
      statusBusy <= 1'b1;
    end else if (csRise && state == fsp_pkg::FSP_MAPDATA) begin
      busyCnt    <= fsp_pkg::BUSY_CNT_W'(PROGRAM_CYC - 1);
      statusBusy <= 1'b1;
    end else if (busyCnt != '0) begin
      busyCnt <= busyCnt - 1'b1;
    end else begin
      statusBusy <= 1'b0;
    end
  end

  // protection status, either method
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      statusProtect <= 1'b0;
    end else begin
      statusProtect <= protActive;
    end
  end

  // array operation check, answered one cycle after request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      opGrant <= 1'b0;
      opDeny  <= 1'b0;
    end else if (opReq) begin
      if (protActive && sectorGuarded(opAddr, protMap[0],
                                      protMap[opAddr[fsp_pkg::SECTOR_MSB:fsp_pkg::SECTOR_LSB]])) begin
        opGrant <= 1'b0;
        opDeny  <= 1'b1;
      end else begin
        opGrant <= 1'b1;
        opDeny  <= 1'b0;
      end
    end else begin
      opGrant <= 1'b0;
      opDeny  <= 1'b0;
    end
  end
endmodule : fsp_ctrl
`default_nettype wire

/* File: fsp_ctrl_monitor.sv */
`default_nettype none
module fsp_ctrl_monitor #(
  parameter int unsigned ERASE_CYC   = fsp_pkg::PROTECT_MAP_ERASE_CYC,
  parameter int unsigned PROGRAM_CYC = fsp_pkg::MAP_PROGRAM_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pins
  input wire logic csN,
  input wire logic wpN,
  input wire logic opReq,
  // answers and status
  input wire logic opGrant,
  input wire logic opDeny,
  input wire logic statusBusy,
  input wire logic statusProtect
);
  timeunit 1ns;
  timeprecision 1ns;
  int wpLowCnt, wpHighCnt, lowRun, highRun, csHighCnt, busyCnt;
  // run lengths of pin levels, chip-select idle and busy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wpLowCnt  <= 0;
      wpHighCnt <= 0;
      lowRun    <= 0;
      highRun   <= 0;
      csHighCnt <= 0;
      busyCnt   <= 0;
    end else begin
      wpLowCnt  <= wpN ? 0 : (wpLowCnt < 999 ? wpLowCnt + 1 : wpLowCnt);
      wpHighCnt <= !wpN ? 0 : (wpHighCnt < 999 ? wpHighCnt + 1 : wpHighCnt);
      lowRun    <= (wpN && wpLowCnt != 0) ? wpLowCnt : lowRun;
      highRun   <= (!wpN && wpHighCnt != 0) ? wpHighCnt : highRun;
      csHighCnt <= !csN ? 0 : (csHighCnt < 999 ? csHighCnt + 1 : csHighCnt);
      busyCnt   <= statusBusy ? busyCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_one_answer; opGrant ^ opDeny; endsequence
  sequence s_wp_held; wpLowCnt == 11; endsequence
  property p_answer; opReq |=> s_one_answer; endproperty
  a_answer: assert property (p_answer) else $error("request lacks a single answer");
  property p_quiet; !opReq |=> !(opGrant || opDeny); endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_deny; opDeny |-> statusProtect || $past(statusProtect); endproperty
  a_deny: assert property (p_deny) else $error("deny while protection off");
  property p_busy_len; $fell(statusBusy) |-> busyCnt == ERASE_CYC || busyCnt == PROGRAM_CYC; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_start; $rose(statusBusy) |-> csHighCnt >= 2 && csHighCnt <= 7; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not tied to select rise");
  property p_wp_assert; s_wp_held |-> statusProtect; endproperty
  a_wp_assert: assert property (p_wp_assert) else $error("pin low did not protect");
  property p_rise; $rose(statusProtect) |-> csHighCnt <= 8 || wpLowCnt >= 4 || lowRun >= 4; endproperty
  a_rise: assert property (p_rise) else $error("protection rose without cause");
  property p_fall; $fell(statusProtect) |-> wpHighCnt >= 4 || highRun >= 4; endproperty
  a_fall: assert property (p_fall) else $error("protection fell with pin low");
  property p_wp_map; $rose(statusBusy) |-> wpLowCnt < 14; endproperty
  a_wp_map: assert property (p_wp_map) else $error("map changed with pin low");
  property p_reset; !$past(nrst) |-> !(statusProtect || statusBusy || opGrant || opDeny); endproperty
  a_reset: assert property (p_reset) else $error("outputs set after reset");
endmodule : fsp_ctrl_monitor
bind fsp_ctrl fsp_ctrl_monitor #(.ERASE_CYC(ERASE_CYC), .PROGRAM_CYC(PROGRAM_CYC)) u_monitor (
  .clock(clock), .nrst(nrst), .csN(csN), .wpN(wpN), .opReq(opReq), .opGrant(opGrant), .opDeny(opDeny),
  .statusBusy(statusBusy), .statusProtect(statusProtect));
`default_nettype wire

/* File: fsp_ctrl_tb.sv */
`default_nettype none
module fsp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BUSY_CYC = 10;
  localparam int          LIMIT    = 60000;
  logic                       clock, nrst, wpN, opReq, csN, sck, si;
  logic                       opGrant, opDeny, statusBusy, statusProtect;
  logic [fsp_pkg::ADDR_W-1:0] opAddr;
  int                         failures = 0;
  int                         cmp_count = 0;
  int                         cycles = 0;
  // design and host
  fsp_ctrl #(.ERASE_CYC(BUSY_CYC), .PROGRAM_CYC(BUSY_CYC)) dut (.clock(clock), .nrst(nrst), .csN(csN), .sck(sck),
    .si(si), .wpN(wpN), .opReq(opReq), .opAddr(opAddr), .opGrant(opGrant), .opDeny(opDeny),
    .statusBusy(statusBusy), .statusProtect(statusProtect));
  fsp_host_model host (.clock(clock), .csN(csN), .sck(sck), .si(si));
  // clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic cmd(input logic [7:0] code);
    host.frame({fsp_pkg::CMD_PREFIX1, fsp_pkg::CMD_PREFIX2, fsp_pkg::CMD_PREFIX3, code});
    #1;
  endtask : cmd
  task automatic op(input logic [3:0] sec, input logic [7:0] page, input logic deny);
    @(posedge clock);
    opReq  <= 1'b1;
    opAddr <= {sec, page, 8'h5a};
    @(posedge clock);
    opReq <= 1'b0;
    #1;
    check({opGrant, opDeny}, {!deny, deny});
  endtask : op
  task automatic wait_idle();
    for (int i = 0; i < 40 && statusBusy !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    check(statusBusy, 1'b0);
  endtask : wait_idle
  task automatic erase(input logic expBusy);
    cmd(fsp_pkg::CMD_ERASE_MAP);
    check(statusBusy, expBusy);
    wait_idle();
  endtask : erase
  task automatic program_map(input logic [7:0] b0, input logic expBusy);
    logic [7:0] q[$];
    q = {fsp_pkg::CMD_PREFIX1, fsp_pkg::CMD_PREFIX2, fsp_pkg::CMD_PREFIX3, fsp_pkg::CMD_PROGRAM_MAP, b0};
    for (int n = 1; n < 16; n++) q.push_back(n[0] ? fsp_pkg::MAP_PROTECTED : fsp_pkg::MAP_UNPROTECTED);
    host.frame(q);
    #1;
    check(statusBusy, expBusy);
    wait_idle();
  endtask : program_map
  task automatic set_wp(input logic lvl);
    @(posedge clock);
    wpN <= lvl;
    repeat (11) @(posedge clock);
    #1;
  endtask : set_wp
  task automatic t_reset_state();
    check(statusProtect, 1'b0);
    op(4'h5, 8'h00, 1'b0);
    cmd(fsp_pkg::CMD_ENABLE_PROTECT);
    check(statusProtect, 1'b1);
    op(4'hf, 8'h10, 1'b0);
    $display("test reset_state done");
  endtask : t_reset_state
  task automatic t_erase_on();
    erase(1'b1);
    for (int s = 0; s < 16; s++) op(s[3:0], 8'h03, 1'b1);
    op(4'h0, 8'hc8, 1'b1);
    cmd(fsp_pkg::CMD_DISABLE_PROTECT);
    check(statusProtect, 1'b0);
    op(4'h7, 8'h00, 1'b0);
    $display("test erase_on done");
  endtask : t_erase_on
  task automatic t_map_codes();
    cmd(fsp_pkg::CMD_ENABLE_PROTECT);
    for (int k = 0; k < 4; k++) begin
      erase(1'b1);
      program_map({k[1] ? 2'b11 : 2'b00, k[0] ? 2'b11 : 2'b00, 4'ha}, 1'b1);
      op(4'h0, 8'h07, k[1]);
      op(4'h0, 8'h08, k[0]);
      op(4'h1, 8'h40, 1'b1);
      op(4'h2, 8'hff, 1'b0);
    end
    program_map(8'h00, 1'b0);
    op(4'h0, 8'h07, 1'b1);
    $display("test map_codes done");
  endtask : t_map_codes
  task automatic t_wp();
    cmd(fsp_pkg::CMD_DISABLE_PROTECT);
    op(4'h3, 8'h00, 1'b0);
    set_wp(1'b0);
    check(statusProtect, 1'b1);
    op(4'h3, 8'h00, 1'b1);
    cmd(fsp_pkg::CMD_DISABLE_PROTECT);
    check(statusProtect, 1'b1);
    erase(1'b0);
    op(4'h4, 8'h00, 1'b0);
    set_wp(1'b1);
    check(statusProtect, 1'b0);
    @(posedge clock);
    wpN <= 1'b0;
    repeat (3) @(posedge clock);
    wpN <= 1'b1;
    set_wp(1'b1);
    check(statusProtect, 1'b0);
    cmd(fsp_pkg::CMD_ENABLE_PROTECT);
    set_wp(1'b0);
    check(statusProtect, 1'b1);
    cmd(fsp_pkg::CMD_DISABLE_PROTECT);
    set_wp(1'b1);
    check(statusProtect, 1'b1);
    cmd(fsp_pkg::CMD_DISABLE_PROTECT);
    set_wp(1'b0);
    cmd(fsp_pkg::CMD_ENABLE_PROTECT);
    set_wp(1'b1);
    check(statusProtect, 1'b1);
    op(4'h5, 8'h00, 1'b1);
    $display("test wp done");
  endtask : t_wp
  task automatic t_reset_mid();
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check(statusProtect, 1'b0);
    op(4'h1, 8'h00, 1'b0);
    cmd(fsp_pkg::CMD_ENABLE_PROTECT);
    check(statusProtect, 1'b1);
    $display("test reset_mid done");
  endtask : t_reset_mid
  // main sequence, pin idles high as if pulled up
  initial begin
    nrst   = 1'b0;
    wpN    = 1'b1;
    opReq  = 1'b0;
    opAddr = '0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    t_reset_state();
    t_erase_on();
    t_map_codes();
    t_wp();
    t_reset_mid();
    complete_run();
  end
endmodule : fsp_ctrl_tb
`default_nettype wire

/* File: fsp_host_model.sv */
`default_nettype none
module fsp_host_model (
  // clock
  input  wire logic clock,
  // serial command pins
  output var  logic csN,
  output var  logic sck,
  output var  logic si
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins at time zero
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end
  // one framed transfer, msb first, slow serial clock, acts on select rise
  task automatic frame(input logic [7:0] bytes[$]);
    @(posedge clock);
    csN <= 1'b0;
    foreach (bytes[i]) begin
      for (int b = 7; b >= 0; b--) begin
        repeat (8) @(posedge clock);
        sck <= 1'b0;
        si  <= bytes[i][b];
        repeat (8) @(posedge clock);
        sck <= 1'b1;
      end
    end
    repeat (8) @(posedge clock);
    sck <= 1'b0;
    repeat (8) @(posedge clock);
    csN <= 1'b1;
    si  <= ~si;
    repeat (8) @(posedge clock);
  endtask : frame
endmodule : fsp_host_model
`default_nettype wire

/* File: fsp_pkg.sv */
`default_nettype none
package fsp_pkg;
  // clock rate
  localparam int unsigned CLOCK_NS                    = 100;
  // map size and sector geometry
  localparam int unsigned MAP_BYTES                   = 16;
  localparam int unsigned MAP_IDX_W                   = 4;
  localparam int unsigned ADDR_W                      = 20;
  localparam int unsigned SECTOR_MSB                  = 19;
  localparam int unsigned SECTOR_LSB                  = 16;
  localparam int unsigned PAGE_MSB                    = 15;
  localparam int unsigned PAGE_LSB                    = 8;
  localparam logic [7:0]  SECTOR0_LOW_LAST_PAGE       = 8'h07;
  // sector 0 map byte fields
  localparam int unsigned SECTOR0_LOW_HALF_MSB        = 7;
  localparam int unsigned SECTOR0_LOW_HALF_LSB        = 6;
  localparam int unsigned SECTOR0_HIGH_HALF_MSB       = 5;
  localparam int unsigned SECTOR0_HIGH_HALF_LSB       = 4;
  localparam logic [1:0]  HALF_PROTECTED              = 2'h3;
  // map byte values
  localparam logic [7:0]  MAP_PROTECTED               = 8'hff;
  localparam logic [7:0]  MAP_UNPROTECTED             = 8'h00;
  localparam logic [7:0]  MAP_RESET_VALUE             = 8'h00;
  localparam logic [7:0]  MAP_ERASED_VALUE            = 8'hff;
  // command bytes
  localparam logic [7:0]  CMD_PREFIX1                 = 8'h3d;
  localparam logic [7:0]  CMD_PREFIX2                 = 8'h2a;
  localparam logic [7:0]  CMD_PREFIX3                 = 8'h7f;
  localparam logic [7:0]  CMD_ENABLE_PROTECT          = 8'ha9;
  localparam logic [7:0]  CMD_DISABLE_PROTECT         = 8'h9a;
  localparam logic [7:0]  CMD_ERASE_MAP               = 8'hcf;
  localparam logic [7:0]  CMD_PROGRAM_MAP             = 8'hfc;
  localparam int unsigned CMD_BYTES                   = 4;
  // timing in ns and derived cycles
  localparam int unsigned PROTECT_ASSERT_DELAY_NS     = 1000;
  localparam int unsigned PROTECT_RELEASE_DELAY_NS    = 1000;
  localparam int unsigned WP_FILTER_NS                = 500;
  localparam int unsigned WP_FILTER_CYC               = (WP_FILTER_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned PROTECT_MAP_ERASE_TIME_NS   = 2000000;
  localparam int unsigned PROTECT_MAP_ERASE_CYC       = PROTECT_MAP_ERASE_TIME_NS / CLOCK_NS;
  localparam int unsigned MAP_PROGRAM_TIME_NS         = 2000000;
  localparam int unsigned MAP_PROGRAM_CYC             = MAP_PROGRAM_TIME_NS / CLOCK_NS;
  localparam int unsigned BUSY_CNT_W                  = 24;
  // command decoder states
  typedef enum logic [3:0] {
    FSP_IDLE    = 4'b0001,
    FSP_OPCODE  = 4'b0010,
    FSP_MAPDATA = 4'b0100,
    FSP_IGNORE  = 4'b1000
  } fsp_state_e;
endpackage : fsp_pkg
`default_nettype wire

/* File: fsp_wp_filter.sv */
`default_nettype none
module fsp_wp_filter #(
  parameter int unsigned FILTER_CYC = fsp_pkg::WP_FILTER_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // raw pin and filtered level
  input  wire logic wpPinN,
  output var  logic wpLow
);
  localparam int unsigned CNT_W = $clog2(FILTER_CYC + 1);

  logic             syncA;
  logic             syncB;
  logic [CNT_W-1:0] stableCnt;

  initial begin
    if (FILTER_CYC < 1) $error("filter length must be at least one cycle");
  end

  // two-flop synchroniser, idles high like the pulled-up pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncA <= 1'b1;
      syncB <= 1'b1;
    end else begin
      syncA <= wpPinN;
      syncB <= syncA;
    end
  end

  // level must hold for FILTER_CYC cycles before it is taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stableCnt <= '0;
      wpLow     <= 1'b0;
    end else if (syncB != wpLow) begin // pin level already matches taken state
      stableCnt <= '0;
    end else if (stableCnt == CNT_W'(FILTER_CYC - 1)) begin
      stableCnt <= '0;
      wpLow     <= ~syncB;
    end else begin
      stableCnt <= stableCnt + 1'b1;
    end
  end
endmodule : fsp_wp_filter
`default_nettype wire
